// File: src/acc_regs.vh
// bit addresses, field positions, reset values and timing counts
`ifndef ACC_REGS_VH
`define ACC_REGS_VH
// status (read) bit addresses
`define ACC_ST_INT        5'h1f
`define ACC_ST_FLAG       5'h1e
`define ACC_ST_MODEM_CHG  5'h1d
`define ACC_ST_CTS        5'h1c
`define ACC_ST_DSR        5'h1b
`define ACC_ST_RTS        5'h1a
`define ACC_ST_TIM_EXP    5'h19
`define ACC_ST_TIM_OVR    5'h18
`define ACC_ST_TX_SHIFT   5'h17
`define ACC_ST_TX_BUF     5'h16
`define ACC_ST_RX_LOADED  5'h15
`define ACC_ST_MODEM_IRQ  5'h14
`define ACC_ST_TIM_IRQ    5'h13
`define ACC_ST_TX_IRQ     5'h11
`define ACC_ST_RX_IRQ     5'h10
`define ACC_ST_RX_PIN     5'h0f
`define ACC_ST_RX_START   5'h0e
`define ACC_ST_RX_FIRST   5'h0d
`define ACC_ST_RX_FER     5'h0c
`define ACC_ST_RX_OVR     5'h0b
`define ACC_ST_RX_PER     5'h0a
`define ACC_ST_RX_ERR     5'h09
// output (write) bit addresses
`define ACC_WR_RESET      5'h1f
`define ACC_WR_MODEM_EN   5'h15
`define ACC_WR_TIM_EN     5'h14
`define ACC_WR_TX_EN      5'h13
`define ACC_WR_RX_EN      5'h12
`define ACC_WR_BREAK      5'h11
`define ACC_WR_RTS        5'h10
`define ACC_WR_TEST       5'h0f
`define ACC_WR_LD_CTRL    5'h0e
`define ACC_WR_LD_INTVL   5'h0d
`define ACC_WR_LD_RXRATE  5'h0c
`define ACC_WR_LD_TXRATE  5'h0b
`define ACC_WR_LAST8      5'h07
`define ACC_WR_LAST11     5'h0a
// control register fields
`define ACC_CTL_LEN_LO    0
`define ACC_CTL_LEN_HI    1
`define ACC_CTL_PAR_ODD   4
`define ACC_CTL_PAR_EN    5
`define ACC_CTL_STOP_LO   6
`define ACC_CTL_STOP_HI   7
`define ACC_RATE_DIV8     10
// reset values
`define ACC_CTL_RST       8'h00
`define ACC_INTVL_RST     8'h00
`define ACC_RATE_RST      11'h001
// timing counts: timer step every 64 clocks, 2 in test mode
`define ACC_TIM_PRE       6'h3f
`define ACC_TIM_PRE_TEST  6'h01
`define ACC_PRE8          3'h7
`endif

// File: src/acc_rate_div.v
// half-bit rate divider: one-cycle tick at twice the bit rate
`timescale 1ns/1ps
module acc_rate_div (
  // clock and reset
  input  wire        ref_clk_in,
  input  wire        rst_n_in,
  // control
  input  wire        clr_in,
  input  wire [10:0] rate_in,
  // tick
  output reg         tick_out
);
`include "acc_regs.vh"
  reg [2:0] pre;
  reg [9:0] cnt;
  wire      pre_done;
  assign pre_done = rate_in[`ACC_RATE_DIV8] ? (pre == `ACC_PRE8) : 1'b1;
  // a rate of zero wraps and divides by 1024
  always @(posedge ref_clk_in) begin
    if (!rst_n_in || clr_in) begin
      pre      <= 3'h0;
      cnt      <= 10'h000;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      pre      <= pre_done ? 3'h0 : pre + 3'h1;
      if (pre_done) begin
        if (cnt == rate_in[9:0] - 10'h001) begin
          cnt      <= 10'h000;
          tick_out <= 1'b1;
        end else begin
          cnt <= cnt + 10'h001;
        end
      end
    end
  end
endmodule

// File: src/acc_buf2.v
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module acc_buf2 (
  // clock and reset
  input  wire       ref_clk_in,
  input  wire       rst_n_in,
  input  wire       flush_in,
  // filling side
  input  wire       in_valid_in,
  input  wire [9:0] in_data_in,
  output wire       in_ready_out,
  // draining side
  output wire       out_valid_out,
  output wire [9:0] out_data_out,
  input  wire       out_ready_in
);
  reg [9:0] slot0;
  reg [9:0] slot1;
  reg [1:0] count;
  wire      push;
  wire      pop;
  assign in_ready_out  = (count != 2'h2);
  assign out_valid_out = (count != 2'h0);
  assign out_data_out  = slot0;
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;
  always @(posedge ref_clk_in) begin
    if (!rst_n_in || flush_in) begin
      count <= 2'h0;
      slot0 <= 10'h000;
      slot1 <= 10'h000;
    end else begin
      if (pop) begin
        slot0 <= (count == 2'h2) ? slot1 : in_data_in;
      end else if (push && count == 2'h0) begin
        slot0 <= in_data_in;
      end
      if (push && (count == 2'h2 || (count == 2'h1 && !pop))) begin
        slot1 <= in_data_in;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// File: src/acc_top.v
// serial controller: status read-back, control writes, transmitter
`timescale 1ns/1ps
// Notes on behaviour
// - status 31 ORs the four enabled interrupts; interrupt pin low when set
// - status 30 is set while any load pointer or break request is set
// - modem line change sets modem flag; write to bit 21 clears it
// - status 28..26 give inverted clear-to-send, data-set-ready, rts pin
// - timer reaching zero sets expired flag; write to bit 20 clears it
// - timer zero while expired still set sets overrun; bit 20 write clears
// - shift empty reads 1 when idle, line high unless break
// - buffer empty set on copy to shifter, cleared by writing buffer bit 7
// - receive loaded set on transfer to buffer, cleared by bit 18 write
// - status 20,19,17,16 are each flag ANDed with its enable
// - status 15 is the receive pin level, not inverted
// - start seen set half a bit after falling edge if line still low
// - first bit seen set one bit after start seen, cleared at end
// - framing error set on low stop bit, cleared by a good stop bit
// - overrun set if transfer while loaded, cleared otherwise
// - parity error follows parity check of each received character
// - status 9 ORs framing, overrun and parity errors
// - status 7..0 give received character, right justified, upper zero
// - reset command sets empty flags, clears break, idles rts and line
// - rts pin follows rts request, pending data or break; sending waits for clear-to-send low
// - active transmitter copies buffer to shifter, updating both flags
// - frame is start 0, data lsb first, parity, stop ones, then recheck
// - length code 00..11 selects 5, 6, 7 or 8 data bits
// - break starts when buffer empty, cts low, requested; holds line low
module acc_top (
  // clock and reset
  input  wire       ref_clk_in,
  input  wire       rst_n_in,
  // bit-addressed cpu port
  input  wire       ce_n_in,
  input  wire [4:0] addr_in,
  input  wire       wr_strobe_in,
  input  wire       wr_data_in,
  output reg        rd_data_out,
  // serial and modem lines
  input  wire       serial_rx_in,
  input  wire       cts_n_in,
  input  wire       dsr_n_in,
  output reg        serial_tx_out,
  output reg        rts_n_out,
  output reg        int_n_out
);
`include "acc_regs.vh"
  localparam TX_IDLE  = 3'h0;
  localparam TX_START = 3'h1;
  localparam TX_DATA  = 3'h2;
  localparam TX_PAR   = 3'h3;
  localparam TX_STOP  = 3'h4;
  localparam TX_BRK   = 3'h5;
  localparam RX_IDLE  = 3'h0;
  localparam RX_START = 3'h1;
  localparam RX_BITS  = 3'h2;
  localparam RX_STOP  = 3'h3;
  localparam RX_HIGH  = 3'h4;

  // keeps only the selected number of data bits
  function [7:0] trim;
    input [7:0] data;
    input [1:0] len;
    begin
      case (len)
        2'h0:    trim = {3'h0, data[4:0]};
        2'h1:    trim = {2'h0, data[5:0]};
        2'h2:    trim = {1'h0, data[6:0]};
        default: trim = data;
      endcase
    end
  endfunction

  // pin synchronisers: s1 feeds s2 only
  reg        rx_s1, rx_s2, rx_s3;
  reg        cts_s1, cts_s2, cts_s3;
  reg        dsr_s1, dsr_s2, dsr_s3;
  // control state
  reg [7:0]  ctrl;
  reg [7:0]  interval;
  reg [10:0] rx_rate;
  reg [10:0] tx_rate;
  reg [7:0]  tx_buf;
  reg        load_ctrl_ptr, load_interval_ptr;
  reg        load_rx_rate_ptr, load_tx_rate_ptr;
  reg        break_request, rts_request, test_mode;
  reg        modem_change_irq_en, timer_irq_en, tx_irq_en, rx_irq_en;
  // flags
  reg        modem_change_flag, timer_expired, timer_overrun;
  reg        tx_shift_empty, tx_buf_empty, rx_buf_loaded;
  reg        rx_start_seen, rx_first_bit_seen;
  reg        rx_framing_err, rx_overrun_err, rx_parity_err;
  reg [7:0]  received_character;
  // timer
  reg [5:0]  tim_pre;
  reg [7:0]  tim_cnt;
  reg        load_interval_ptr_q;
  // transmitter
  reg [2:0]  tx_state;
  reg [7:0]  tx_shift;
  reg        tx_par;
  reg        tx_half;
  reg [2:0]  tx_cnt;
  reg        tx_clr;
  wire       tx_tick;
  wire       tx_tick_raw;
  // receiver
  reg [2:0]  rx_state;
  reg [7:0]  rx_shift;
  reg        rx_pbit;
  reg        rx_half;
  reg [3:0]  rx_cnt;
  reg        rx_clr;
  reg        rx_push;
  reg [9:0]  rx_word;
  wire       rx_tick;
  wire       rx_tick_raw;
  wire       rx_in_ready;
  wire       rx_out_valid;
  wire [9:0] rx_out_data;
  wire       rx_take;

  wire       wr;
  wire       soft_rst;
  wire [1:0] len;
  wire [3:0] nbits;
  wire [2:0] stop_halves;
  wire       par_on;
  wire       rts_on;
  wire       mod_irq, tim_irq, txb_irq, rxb_irq;
  wire [31:0] stat;
  wire       tim_step;

  assign wr       = !ce_n_in && wr_strobe_in;
  assign soft_rst = wr && addr_in == `ACC_WR_RESET && wr_data_in;
  assign len      = {ctrl[`ACC_CTL_LEN_HI], ctrl[`ACC_CTL_LEN_LO]};
  assign nbits    = 4'h5 + {2'h0, len};
  assign par_on   = ctrl[`ACC_CTL_PAR_EN];
  // stop select: 00 one and a half, 01 two, 1x one
  assign stop_halves = ctrl[`ACC_CTL_STOP_HI] ? 3'h2 :
                       ctrl[`ACC_CTL_STOP_LO] ? 3'h4 : 3'h3;
  assign rts_on  = !rts_n_out;
  assign mod_irq = modem_change_flag && modem_change_irq_en;
  assign tim_irq = timer_expired && timer_irq_en;
  assign txb_irq = tx_buf_empty && tx_irq_en;
  assign rxb_irq = rx_buf_loaded && rx_irq_en;
  assign rx_take = rx_out_valid && !soft_rst;
  // a tick issued before the divider saw its clear is stale
  assign tx_tick = tx_tick_raw && !tx_clr;
  assign rx_tick = rx_tick_raw && !rx_clr;

  assign stat = {
    mod_irq | tim_irq | txb_irq | rxb_irq,
    load_ctrl_ptr | load_interval_ptr | load_rx_rate_ptr |
      load_tx_rate_ptr | break_request,
    modem_change_flag,
    !cts_s2, !dsr_s2, !rts_n_out,
    timer_expired, timer_overrun, tx_shift_empty, tx_buf_empty,
    rx_buf_loaded, mod_irq, tim_irq, 1'b0, txb_irq, rxb_irq,
    rx_s2,
    rx_start_seen, rx_first_bit_seen,
    rx_framing_err, rx_overrun_err, rx_parity_err,
    rx_framing_err | rx_overrun_err | rx_parity_err,
    1'b0,
    received_character
  };

  acc_rate_div u_tx_div (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .clr_in     (tx_clr),
    .rate_in    (tx_rate),
    .tick_out   (tx_tick_raw)
  );
  acc_rate_div u_rx_div (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .clr_in     (rx_clr),
    .rate_in    (rx_rate),
    .tick_out   (rx_tick_raw)
  );
  // absorbs a character while the previous transfer is still settling
  acc_buf2 u_rx_buf (
    .ref_clk_in    (ref_clk_in),
    .rst_n_in      (rst_n_in),
    .flush_in      (soft_rst),
    .in_valid_in   (rx_push),
    .in_data_in    (rx_word),
    .in_ready_out  (rx_in_ready),
    .out_valid_out (rx_out_valid),
    .out_data_out  (rx_out_data),
    .out_ready_in  (!soft_rst)
  );

  // synchronisers and registered outputs
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      {rx_s1, rx_s2, rx_s3}    <= 3'h7;
      {cts_s1, cts_s2, cts_s3} <= 3'h7;
      {dsr_s1, dsr_s2, dsr_s3} <= 3'h7;
      rd_data_out <= 1'b0;
      int_n_out   <= 1'b1;
    end else begin
      rx_s1  <= serial_rx_in;
      rx_s2  <= rx_s1;
      rx_s3  <= rx_s2;
      cts_s1 <= cts_n_in;
      cts_s2 <= cts_s1;
      cts_s3 <= cts_s2;
      dsr_s1 <= dsr_n_in;
      dsr_s2 <= dsr_s1;
      dsr_s3 <= dsr_s2;
      rd_data_out <= stat[addr_in];
      int_n_out   <= !stat[`ACC_ST_INT];
    end
  end

  // control writes, register loading and timer
  always @(posedge ref_clk_in) begin
    if (!rst_n_in || soft_rst) begin
      ctrl              <= `ACC_CTL_RST;
      interval          <= `ACC_INTVL_RST;
      rx_rate           <= `ACC_RATE_RST;
      tx_rate           <= `ACC_RATE_RST;
      load_ctrl_ptr     <= 1'b1;
      load_interval_ptr <= 1'b1;
      load_rx_rate_ptr  <= 1'b1;
      load_tx_rate_ptr  <= 1'b1;
      break_request     <= 1'b0;
      rts_request       <= 1'b0;
      test_mode         <= 1'b0;
      modem_change_irq_en <= 1'b0;
      timer_irq_en      <= 1'b0;
      tx_irq_en         <= 1'b0;
      rx_irq_en         <= 1'b0;
      modem_change_flag <= 1'b0;
      timer_expired     <= 1'b0;
      timer_overrun     <= 1'b0;
      tim_pre           <= 6'h00;
      tim_cnt           <= 8'h00;
      load_interval_ptr_q            <= 1'b1;
    end else begin
      load_interval_ptr_q <= load_interval_ptr;
      if (wr) begin
        case (addr_in)
          `ACC_WR_MODEM_EN: begin
            modem_change_irq_en <= wr_data_in;
            modem_change_flag   <= 1'b0;
          end
          `ACC_WR_TIM_EN: begin
            timer_irq_en  <= wr_data_in;
            timer_expired <= 1'b0;
            timer_overrun <= 1'b0;
          end
          `ACC_WR_TX_EN:     tx_irq_en         <= wr_data_in;
          `ACC_WR_RX_EN:     rx_irq_en         <= wr_data_in;
          `ACC_WR_BREAK:     break_request     <= wr_data_in;
          `ACC_WR_RTS:       rts_request       <= wr_data_in;
          `ACC_WR_TEST:      test_mode         <= wr_data_in;
          `ACC_WR_LD_CTRL:   load_ctrl_ptr     <= wr_data_in;
          `ACC_WR_LD_INTVL:  load_interval_ptr <= wr_data_in;
          `ACC_WR_LD_RXRATE: load_rx_rate_ptr  <= wr_data_in;
          `ACC_WR_LD_TXRATE: load_tx_rate_ptr  <= wr_data_in;
          default: begin
            if (addr_in <= `ACC_WR_LAST11) begin
              if (load_ctrl_ptr) begin
                if (addr_in <= `ACC_WR_LAST8)
                  ctrl[addr_in[2:0]] <= wr_data_in;
                if (addr_in == `ACC_WR_LAST8)
                  load_ctrl_ptr <= 1'b0;
              end else if (load_interval_ptr) begin
                if (addr_in <= `ACC_WR_LAST8)
                  interval[addr_in[2:0]] <= wr_data_in;
                if (addr_in == `ACC_WR_LAST8)
                  load_interval_ptr <= 1'b0;
              end else if (load_rx_rate_ptr || load_tx_rate_ptr) begin
                if (load_rx_rate_ptr)
                  rx_rate[addr_in[3:0]] <= wr_data_in;
                if (load_tx_rate_ptr)
                  tx_rate[addr_in[3:0]] <= wr_data_in;
                if (addr_in == `ACC_WR_LAST11) begin
                  load_rx_rate_ptr <= 1'b0;
                  load_tx_rate_ptr <= 1'b0;
                end
              end
            end
          end
        endcase
      end
      // line change sets the flag after the clear above, so set wins;
      // a glitch shorter than one clock may be missed
      if ((cts_s2 != cts_s3) || (dsr_s2 != dsr_s3))
        modem_change_flag <= 1'b1;
      // leaving interval load restarts the timer
      if (load_interval_ptr_q && !load_interval_ptr) begin
        tim_cnt <= interval;
        tim_pre <= 6'h00;
      end else if (!load_interval_ptr) begin
        tim_pre <= tim_step ? 6'h00 : tim_pre + 6'h01;
        if (tim_step) begin
          if (tim_cnt == 8'h01) begin
            tim_cnt       <= interval;
            timer_expired <= 1'b1;
            if (timer_expired)
              timer_overrun <= 1'b1;
          end else begin
            tim_cnt <= tim_cnt - 8'h01;
          end
        end
      end
    end
  end
  assign tim_step = tim_pre ==
                    (test_mode ? `ACC_TIM_PRE_TEST : `ACC_TIM_PRE);

  // transmitter
  always @(posedge ref_clk_in) begin
    if (!rst_n_in || soft_rst) begin
      tx_state       <= TX_IDLE;
      tx_shift_empty <= 1'b1;
      tx_buf_empty   <= 1'b1;
      serial_tx_out  <= 1'b1;
      rts_n_out      <= 1'b1;
      tx_buf         <= 8'h00;
      tx_shift       <= 8'h00;
      tx_par         <= 1'b0;
      tx_half        <= 1'b0;
      tx_cnt         <= 3'h0;
      tx_clr         <= 1'b1;
    end else begin
      tx_clr <= 1'b0;
      // rts drops only once pending data and break are finished
      rts_n_out <= !(rts_request || !tx_shift_empty ||
                     !tx_buf_empty || break_request);
      // buffer loading is blocked while any pointer or break is set
      if (wr && addr_in <= `ACC_WR_LAST8 && !load_ctrl_ptr &&
          !load_interval_ptr && !load_rx_rate_ptr &&
          !load_tx_rate_ptr && !break_request) begin
        tx_buf[addr_in[2:0]] <= wr_data_in;
        if (addr_in == `ACC_WR_LAST8)
          tx_buf_empty <= 1'b0;
      end
      if (tx_tick)
        tx_half <= !tx_half;
      case (tx_state)
        TX_IDLE: begin
          serial_tx_out <= 1'b1;
          if (rts_on && !cts_s2) begin
            if (!tx_buf_empty) begin
              tx_shift       <= trim(tx_buf, len);
              tx_par         <= ^trim(tx_buf, len) ^
                                ctrl[`ACC_CTL_PAR_ODD];
              tx_buf_empty   <= 1'b1;
              tx_shift_empty <= 1'b0;
              serial_tx_out  <= 1'b0;
              tx_half        <= 1'b0;
              tx_cnt         <= 3'h0;
              tx_clr         <= 1'b1;
              tx_state       <= TX_START;
            end else if (break_request) begin
              serial_tx_out <= 1'b0;
              tx_state      <= TX_BRK;
            end
          end
        end
        TX_START: begin
          if (tx_tick && tx_half) begin
            serial_tx_out <= tx_shift[0];
            tx_state      <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_tick && tx_half) begin
            if ({1'b0, tx_cnt} == nbits - 4'h1) begin
              serial_tx_out <= par_on ? tx_par : 1'b1;
              tx_cnt        <= 3'h0;
              tx_state      <= par_on ? TX_PAR : TX_STOP;
            end else begin
              serial_tx_out <= tx_shift[1];
              tx_shift      <= {1'b0, tx_shift[7:1]};
              tx_cnt        <= tx_cnt + 3'h1;
            end
          end
        end
        TX_PAR: begin
          if (tx_tick && tx_half) begin
            serial_tx_out <= 1'b1;
            tx_state      <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (tx_tick) begin
            if (tx_cnt == stop_halves - 3'h1) begin
              tx_shift_empty <= 1'b1;
              tx_state       <= TX_IDLE;
            end else begin
              tx_cnt <= tx_cnt + 3'h1;
            end
          end
        end
        TX_BRK: begin
          serial_tx_out <= 1'b0;
          if (!break_request) begin
            serial_tx_out <= 1'b1;
            tx_state      <= TX_IDLE;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // receiver
  always @(posedge ref_clk_in) begin
    if (!rst_n_in || soft_rst) begin
      rx_state           <= RX_IDLE;
      rx_shift           <= 8'h00;
      rx_pbit            <= 1'b0;
      rx_half            <= 1'b0;
      rx_cnt             <= 4'h0;
      rx_clr             <= 1'b1;
      rx_push            <= 1'b0;
      rx_word            <= 10'h000;
      rx_start_seen      <= 1'b0;
      rx_first_bit_seen  <= 1'b0;
      rx_buf_loaded      <= 1'b0;
      rx_framing_err     <= 1'b0;
      rx_overrun_err     <= 1'b0;
      rx_parity_err      <= 1'b0;
      received_character <= 8'h00;
    end else begin
      rx_clr  <= 1'b0;
      rx_push <= 1'b0;
      if (rx_tick)
        rx_half <= !rx_half;
      case (rx_state)
        RX_IDLE: begin
          if (rx_s3 && !rx_s2) begin
            rx_clr   <= 1'b1;
            rx_half  <= 1'b0;
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (rx_tick) begin
            rx_half <= 1'b0;
            rx_cnt  <= 4'h0;
            if (!rx_s2) begin
              rx_start_seen <= 1'b1;
              rx_state      <= RX_BITS;
            end else begin
              rx_state <= RX_IDLE;
            end
          end
        end
        RX_BITS: begin
          if (rx_tick && rx_half) begin
            rx_first_bit_seen <= 1'b1;
            if (rx_cnt < nbits)
              rx_shift <= {rx_s2, rx_shift[7:1]};
            else
              rx_pbit <= rx_s2;
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt == nbits - {3'h0, !par_on})
              rx_state <= RX_STOP;
          end
        end
        RX_STOP: begin
          // waits on a full buffer rather than dropping the character
          if (rx_tick && rx_half && rx_in_ready) begin
            rx_word[7:0] <= rx_shift >> (4'h8 - nbits);
            rx_word[8]   <= !rx_s2;
            rx_word[9]   <= par_on && (rx_pbit != (^trim(rx_shift >>
                            (4'h8 - nbits), len) ^
                            ctrl[`ACC_CTL_PAR_ODD]));
            rx_push           <= 1'b1;
            rx_start_seen     <= 1'b0;
            rx_first_bit_seen <= 1'b0;
            rx_state          <= rx_s2 ? RX_IDLE : RX_HIGH;
          end
        end
        RX_HIGH: begin
          if (rx_s2)
            rx_state <= RX_IDLE;
        end
        default: rx_state <= RX_IDLE;
      endcase
      if (wr && addr_in == `ACC_WR_RX_EN)
        rx_buf_loaded <= 1'b0;
      // transfer comes after the clear, so a new character wins
      if (rx_take) begin
        received_character <= rx_out_data[7:0];
        rx_framing_err     <= rx_out_data[8];
        rx_parity_err      <= rx_out_data[9];
        rx_overrun_err     <= rx_buf_loaded;
        rx_buf_loaded      <= 1'b1;
      end
    end
  end
endmodule

// File: test/acc_monitor.sv
// port assertions for the serial controller
`timescale 1ns/1ps
module acc_monitor (
  // clock and reset
  input wire       ref_clk_in,
  input wire       rst_n_in,
  // cpu port
  input wire       ce_n_in,
  input wire [4:0] addr_in,
  input wire       wr_strobe_in,
  input wire       wr_data_in,
  input wire       rd_data_out,
  // serial and modem lines
  input wire       serial_rx_in,
  input wire       cts_n_in,
  input wire       dsr_n_in,
  input wire       serial_tx_out,
  input wire       rts_n_out,
  input wire       int_n_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  rst_idle_a: assert property (disable iff (1'b0) !rst_n_in |=>
    serial_tx_out && rts_n_out && int_n_out) else $error("not idle");
  rx_pin_a: assert property ($stable(serial_rx_in)[*4] ##0
    addr_in == 5'h0f |=> rd_data_out == $past(serial_rx_in))
    else $error("rx pin readback");
  cts_read_a: assert property ($stable(cts_n_in)[*4] ##0
    addr_in == 5'h1c |=> rd_data_out == !$past(cts_n_in))
    else $error("cts readback");
  rts_read_a: assert property (addr_in == 5'h1a && $stable(rts_n_out)
    |=> rd_data_out == !$past(rts_n_out)) else $error("rts readback");
  int_pin_a: assert property (addr_in == 5'h1f |=>
    rd_data_out == !int_n_out) else $error("int pin mismatch");
  tx_rts_a: assert property ($fell(serial_tx_out) |-> !rts_n_out)
    else $error("sent without rts");
  tx_cts_a: assert property ($fell(serial_tx_out) |->
    !$past(cts_n_in, 3)) else $error("sent without cts");
  bit_width_a: assert property ($rose(serial_tx_out) |=>
    serial_tx_out) else $error("short one bit");
endmodule
bind acc_top acc_monitor mon (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
  .ce_n_in(ce_n_in), .addr_in(addr_in), .wr_strobe_in(wr_strobe_in),
  .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
  .serial_rx_in(serial_rx_in), .cts_n_in(cts_n_in), .dsr_n_in(dsr_n_in),
  .serial_tx_out(serial_tx_out), .rts_n_out(rts_n_out),
  .int_n_out(int_n_out));

// File: test/acc_line_model.sv
// far terminal: echoes the line back and answers rts with cts
`timescale 1ns/1ps
module acc_line_model (
  // clock and controller side
  input  wire ref_clk_in,
  input  wire tx_in,
  input  wire rts_n_in,
  // bench control
  input  wire stall_in,
  input  wire dsr_in,
  // to the controller
  output wire rx_out,
  output reg  cts_n_out,
  output wire dsr_n_out
);
  assign rx_out = tx_in;
  assign dsr_n_out = ~dsr_in;
  initial cts_n_out = 1'b1;
  // registered, so each change follows rts_n_in or stall_in by one cycle
  always @(posedge ref_clk_in) begin
    cts_n_out <= rts_n_in | stall_in;
  end
endmodule

// File: test/tb_top.sv
// self-checking bench for the serial controller
`timescale 1ns/1ps
module tb_top;
  reg        ref_clk_in, rst_n_in, ce_n_in, wr_strobe_in, wr_data_in;
  reg        stall, dsr;
  reg  [4:0] addr_in;
  reg  [5:0] rows [0:7];
  wire       rd_data_out, rx, cts_n, dsr_n, tx, rts_n, int_n;
  integer    err_count, checks, i;
  integer    cycles = 0;
  acc_top dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .ce_n_in(ce_n_in), .addr_in(addr_in), .wr_strobe_in(wr_strobe_in),
    .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
    .serial_rx_in(rx), .cts_n_in(cts_n), .dsr_n_in(dsr_n),
    .serial_tx_out(tx), .rts_n_out(rts_n), .int_n_out(int_n));
  acc_line_model far (.ref_clk_in(ref_clk_in), .tx_in(tx), .rts_n_in(rts_n),
    .stall_in(stall), .dsr_in(dsr), .rx_out(rx), .cts_n_out(cts_n),
    .dsr_n_out(dsr_n));
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input got, input exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("Error at %0t: got %b want %b", $time, got, exp);
      end
    end
  endtask
  task wr(input [4:0] a, input d);
    begin
      @(negedge ref_clk_in);
      ce_n_in = 1'b0;
      addr_in = a;
      wr_data_in = d;
      wr_strobe_in = 1'b1;
      @(negedge ref_clk_in);
      wr_strobe_in = 1'b0;
      ce_n_in = 1'b1;
    end
  endtask
  // lsb first; the last bit clears the load pointer
  task wrv(input [10:0] v, input integer n);
    integer k;
    for (k = 0; k < n; k = k + 1) wr(k[4:0], v[k]);
  endtask
  task rd(input [4:0] a, input e);
    begin
      @(negedge ref_clk_in);
      addr_in = a;
      @(negedge ref_clk_in);
      chk(rd_data_out, e);
    end
  endtask
  task rdc(input [7:0] e);
    integer k;
    for (k = 0; k < 8; k = k + 1) rd(k[4:0], e[k]);
  endtask
  task poll(input [4:0] a);
    integer k;
    begin
      k = 0;
      addr_in = a;
      @(negedge ref_clk_in);
      while (rd_data_out !== 1'b1 && k < 500) begin
        @(negedge ref_clk_in);
        k = k + 1;
      end
      chk(rd_data_out, 1'b1);
    end
  endtask
  // control, interval 0, both rates 1 (tick every clock)
  task cfg(input [7:0] c);
    begin
      wrv({3'h0, c}, 8);
      wrv(11'h000, 8);
      wrv(11'h001, 11);
    end
  endtask
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      end_of_test;
    end
  end
  initial begin
    {rst_n_in, wr_strobe_in, wr_data_in, stall, dsr} = 5'h00;
    ce_n_in = 1'b1;
    addr_in = 5'h00;
    err_count = 0;
    checks = 0;
    {rows[0], rows[1], rows[2], rows[3]} = {6'h3e, 6'h3d, 6'h38, 6'h34};
    {rows[4], rows[5], rows[6], rows[7]} = {6'h2f, 6'h2d, 6'h2a, 6'h1f};
    repeat (16) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    chk(tx & rts_n & int_n, 1'b1);
    for (i = 0; i < 8; i = i + 1) rd(rows[i][5:1], rows[i][0]);
    $display("reset rows done");
    cfg(8'h83);
    rd(5'h1e, 1'b0);
    wr(5'h12, 1'b1);
    wr(5'h10, 1'b1);
    repeat (8) @(negedge ref_clk_in);
    rd(5'h1c, 1'b1);
    rd(5'h1d, 1'b1);
    wr(5'h15, 1'b0);
    rd(5'h1d, 1'b0);
    stall = 1'b1;
    repeat (8) @(negedge ref_clk_in);
    wrv(11'h0a5, 8);
    rd(5'h16, 1'b0);
    rd(5'h17, 1'b1);
    stall = 1'b0;
    poll(5'h15);
    rdc(8'ha5);
    rd(5'h10, 1'b1);
    chk(int_n, 1'b0);
    rd(5'h09, 1'b0);
    $display("frame done");
    wrv(11'h03c, 8);
    poll(5'h0b);
    rd(5'h09, 1'b1);
    rdc(8'h3c);
    wr(5'h12, 1'b0);
    rd(5'h15, 1'b0);
    chk(int_n, 1'b1);
    $display("overrun done");
    wr(5'h1f, 1'b1);
    rd(5'h1e, 1'b1);
    rd(5'h16, 1'b1);
    cfg(8'h80);
    wr(5'h10, 1'b1);
    repeat (8) @(negedge ref_clk_in);
    wrv(11'h0ff, 8);
    poll(5'h15);
    rdc(8'h1f);
    rd(5'h0b, 1'b0);
    $display("length done");
    wr(5'h11, 1'b1);
    rd(5'h1e, 1'b1);
    poll(5'h0e);
    poll(5'h0d);
    poll(5'h0c);
    rd(5'h09, 1'b1);
    chk(tx, 1'b0);
    wr(5'h11, 1'b0);
    rd(5'h1e, 1'b0);
    chk(tx, 1'b1);
    $display("break done");
    wr(5'h0f, 1'b1);
    wr(5'h0d, 1'b1);
    wrv(11'h002, 8);
    poll(5'h19);
    poll(5'h18);
    $display("timer done");
    end_of_test;
  end
endmodule
